// *** sfif_defs.vh ***
// constants for the serial flash instruction front end
`ifndef SFIF_DEFS_VH
`define SFIF_DEFS_VH
`define SFIF_OP_RD      8'h03
`define SFIF_OP_FRD     8'h0B
`define SFIF_OP_DOR     8'h3B
`define SFIF_OP_QOR     8'h6B
`define SFIF_OP_DIO     8'hBB
`define SFIF_OP_QIO     8'hEB
`define SFIF_OP_WRAP    8'h77
`define SFIF_OP_ID      8'hAB
`define SFIF_OP_DID     8'h92
`define SFIF_OP_SECRD   8'h48
`define SFIF_OP_SECER   8'h44
`define SFIF_OP_SECPG   8'h42
`define SFIF_OP_WREN    8'h06
`define SFIF_OP_VWREN   8'h50
`define SFIF_OP_WRDI    8'h04
`define SFIF_OP_RDSR1   8'h05
`define SFIF_OP_RDSR2   8'h35
`define SFIF_OP_WRSR    8'h01
`define SFIF_OP_PP      8'h02
`define SFIF_OP_QPP     8'h32
`define SFIF_OP_SE      8'h20
`define SFIF_OP_BE32    8'h52
`define SFIF_OP_BE64    8'hD8
`define SFIF_OP_CE1     8'hC7
`define SFIF_OP_CE2     8'h60
`define SFIF_SEC_R0     8'h00
`define SFIF_SEC_R1     8'h10
`define SFIF_SEC_R2     8'h20
`define SFIF_SEC_R3     8'h30
`define SFIF_ADDR_BITS  6'd24
`define SFIF_DUMMY_BITS 6'd8
`define SFIF_ID_DUMMY   6'd24
`define SFIF_QIO_GAP    6'd4
`define SFIF_WRAP_NIB   6'd6
`endif

// *** sfif_sync.v ***
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfif_sync
#(
  parameter W = 1
)
(
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  input  wire [W-1:0] rst_val_i,
  output reg  [W-1:0] q_o
);
  reg [W-1:0] meta_q;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta_q <= rst_val_i;
      q_o    <= rst_val_i;
    end
    else
    begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// *** sfif_fifo.v ***
// small fifo holding bytes from the array read port
`timescale 1ns/1ps
module sfif_fifo
#(
  parameter W = 8,
  parameter D = 4,
  parameter A = 2
)
(
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         flush_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem [0:D-1];
  reg [A:0]   wp_q;
  reg [A:0]   rp_q;
  wire        full  = (wp_q[A] != rp_q[A]) && (wp_q[A-1:0] == rp_q[A-1:0]);
  wire        empty = (wp_q == rp_q);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem[rp_q[A-1:0]];
  always @(posedge clk_i)
  begin
    if (in_valid_i && !full)
      mem[wp_q[A-1:0]] <= in_data_i;
  end
  always @(posedge clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wp_q <= {(A+1){1'b0}};
      rp_q <= {(A+1){1'b0}};
    end
    else
    begin
      if (in_valid_i && !full)
        wp_q <= wp_q + 1'b1;
      if (out_ready_i && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule

// *** sfif_top.v ***
// serial flash instruction front end: decode, shift, write latch
`timescale 1ns/1ps
`include "sfif_defs.vh"
module sfif_top
#(
  parameter FIFO_W     = 8,
  parameter FIFO_D     = 4,
  parameter FIFO_A     = 2,
  parameter PART_CODE  = 8'h5A,
  parameter MAKER_CODE = 8'hA5
)
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        select_n_i,
  input  wire        sclk_i,
  input  wire [3:0]  lane_i,
  output reg  [3:0]  lane_o,
  output reg  [3:0]  lane_oe_o,
  input  wire        busy_i,
  input  wire [7:0]  status1_i,
  input  wire [7:0]  status2_i,
  input  wire        op_done_i,
  output reg         write_latch_flag_o,
  output reg         vol_arm_o,
  output reg         rd_req_o,
  output reg  [23:0] rd_addr_o,
  input  wire        rd_valid_i,
  output wire        rd_ready_o,
  input  wire [7:0]  rd_data_i,
  output reg         wr_cmd_o,
  output reg  [7:0]  wr_op_o,
  output reg  [23:0] wr_addr_o,
  output reg  [6:4]  wrap_setting_bits_o,
  output reg         wrap_set_o,
  output reg         sec_sel_valid_o,
  output reg  [1:0]  sec_sel_o
);
  // ph_* are one-hot phase codes
  localparam [6:0] PH_OP   = 7'h01;
  localparam [6:0] PH_ADR  = 7'h02;
  localparam [6:0] PH_MODE = 7'h04;
  localparam [6:0] PH_DUM  = 7'h08;
  localparam [6:0] PH_OUT  = 7'h10;
  localparam [6:0] PH_IN   = 7'h20;
  localparam [6:0] PH_IGN  = 7'h40;

  // bits delivered per sclk edge for a lane width code
  function [5:0] step;
    input [1:0] w;
    begin
      case (w)
        2'd1:    step = 6'd2;
        2'd2:    step = 6'd4;
        default: step = 6'd1;
      endcase
    end
  endfunction

  // write commands that need the latch (or, for WRSR, the volatile arm) and a byte boundary
  function is_wr;
    input [7:0] op;
    begin
      case (op)
        `SFIF_OP_PP, `SFIF_OP_QPP, `SFIF_OP_SE, `SFIF_OP_BE32, `SFIF_OP_BE64,
        `SFIF_OP_CE1, `SFIF_OP_CE2, `SFIF_OP_WRSR, `SFIF_OP_SECER,
        `SFIF_OP_SECPG: is_wr = 1'b1;
        default:        is_wr = 1'b0;
      endcase
    end
  endfunction

  wire [5:0] pin_s;
  sfif_sync #(.W(6)) u_sync
  (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .d_i       ({select_n_i, sclk_i, lane_i}),
    .rst_val_i (6'b100000),
    .q_o       (pin_s)
  );
  wire       sel_n = pin_s[5];
  wire       sck   = pin_s[4];
  wire [3:0] din   = pin_s[3:0];

  reg        sck_q;
  reg        sel_q;
  reg  [6:0] ph_q;
  reg  [7:0] op_q;
  reg  [7:0] sh_q;
  reg  [5:0] cnt_q;
  reg  [2:0] bitc_q;
  reg  [1:0] inw_q;
  reg  [1:0] outw_q;
  reg  [23:0] adr_q;
  reg  [7:0] osh_q;
  reg  [3:0] oleft_q;
  reg        idsel_q;
  reg        from_fifo_q;
  reg        pop_q;
  reg        cap_q;

  wire rise    = sck && !sck_q;
  wire fall    = !sck && sck_q;
  wire sel_up  = sel_n && !sel_q;
  wire [5:0] stp = step(inw_q);
  wire [7:0] op_nx = {sh_q[6:0], din[0]};

  wire       f_valid;
  wire [7:0] f_data;
  sfif_fifo #(.W(FIFO_W), .D(FIFO_D), .A(FIFO_A)) u_fifo
  (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .flush_i     (sel_n),
    .in_valid_i  (rd_valid_i),
    .in_ready_o  (rd_ready_o),
    .in_data_i   (rd_data_i),
    .out_valid_o (f_valid),
    .out_ready_i (pop_q),
    .out_data_o  (f_data)
  );

  // byte to load at each output byte boundary
  reg [7:0] nxt_byte;
  always @*
  begin
    nxt_byte = 8'h00;
    case (op_q)
      `SFIF_OP_RDSR1: nxt_byte = status1_i;
      `SFIF_OP_RDSR2: nxt_byte = status2_i;
      `SFIF_OP_ID:    nxt_byte = PART_CODE;
      `SFIF_OP_DID:   nxt_byte = idsel_q ? PART_CODE : MAKER_CODE;
      default:        nxt_byte = f_valid ? f_data : 8'hFF;
    endcase
  end

  wire [3:0] obits = (outw_q == 2'd2) ? osh_q[7:4] :
                     (outw_q == 2'd1) ? {2'b00, osh_q[7:6]} : {2'b00, osh_q[7], 1'b0};
  wire [5:0] ostp_w = step(outw_q);
  wire [3:0] ostp  = {1'b0, ostp_w[2:0]};

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sck_q <= 1'b0;
      sel_q <= 1'b1;
      ph_q <= PH_IGN;
      op_q <= 8'h00;
      sh_q <= 8'h00;
      cnt_q <= 6'd0;
      bitc_q <= 3'd0;
      inw_q <= 2'd0;
      outw_q <= 2'd0;
      adr_q <= 24'h000000;
      osh_q <= 8'h00;
      oleft_q <= 4'd0;
      idsel_q <= 1'b0;
      from_fifo_q <= 1'b0;
      pop_q <= 1'b0;
      cap_q <= 1'b0;
      lane_o <= 4'h0;
      lane_oe_o <= 4'h0;
      write_latch_flag_o <= 1'b0;
      vol_arm_o <= 1'b0;
      rd_req_o <= 1'b0;
      rd_addr_o <= 24'h000000;
      wr_cmd_o <= 1'b0;
      wr_op_o <= 8'h00;
      wr_addr_o <= 24'h000000;
      wrap_setting_bits_o <= 3'b000;
      wrap_set_o <= 1'b0;
      sec_sel_valid_o <= 1'b0;
      sec_sel_o <= 2'd0;
    end
    else
    begin
      sck_q <= sck;
      sel_q <= sel_n;
      pop_q <= 1'b0;
      rd_req_o <= 1'b0;
      wr_cmd_o <= 1'b0;
      wrap_set_o <= 1'b0;
      if (op_done_i)
        write_latch_flag_o <= 1'b0;
      if (sel_n)
      begin
        ph_q <= PH_OP;
        cnt_q <= 6'd0;
        bitc_q <= 3'd0;
        inw_q <= 2'd0;
        idsel_q <= 1'b0;
        lane_oe_o <= 4'h0;
        if (sel_up && ph_q != PH_IGN && is_wr(op_q) && bitc_q == 3'd0 && !busy_i)
        begin
          if (write_latch_flag_o || (op_q == `SFIF_OP_WRSR && vol_arm_o))
          begin
            wr_cmd_o <= 1'b1;
            wr_op_o <= op_q;
            wr_addr_o <= adr_q;
            if (op_q == `SFIF_OP_WRSR)
              vol_arm_o <= 1'b0;
          end
        end
        // single-byte opcodes park in the input phase once complete
        if (sel_up && ph_q == PH_IN && bitc_q == 3'd0 && !busy_i)
        begin
          if (op_q == `SFIF_OP_WREN)
            write_latch_flag_o <= 1'b1;
          if (op_q == `SFIF_OP_VWREN)
            vol_arm_o <= 1'b1;
          if (op_q == `SFIF_OP_WRDI)
          begin
            write_latch_flag_o <= 1'b0;
            vol_arm_o <= 1'b0;
          end
        end
        if (sel_up)
          op_q <= 8'h00;
      end
      else if (rise)
      begin
        bitc_q <= bitc_q + stp[2:0];
        case (ph_q)
          PH_OP:
          begin
            sh_q <= op_nx;
            if (bitc_q == 3'd7)
            begin
              op_q <= op_nx;
              cnt_q <= 6'd0;
              ph_q <= PH_ADR;
              case (op_nx)
                `SFIF_OP_RDSR1, `SFIF_OP_RDSR2:
                begin
                  ph_q <= PH_OUT;
                  outw_q <= 2'd0;
                end
                `SFIF_OP_DIO, `SFIF_OP_DID: inw_q <= 2'd1;
                `SFIF_OP_QIO, `SFIF_OP_WRAP: inw_q <= 2'd2;
                `SFIF_OP_ID: ph_q <= PH_DUM;
                `SFIF_OP_RD, `SFIF_OP_FRD, `SFIF_OP_DOR, `SFIF_OP_QOR,
                `SFIF_OP_SECRD, `SFIF_OP_SECER, `SFIF_OP_SECPG, `SFIF_OP_PP,
                `SFIF_OP_QPP, `SFIF_OP_SE, `SFIF_OP_BE32, `SFIF_OP_BE64: ph_q <= PH_ADR;
                default: ph_q <= PH_IN;
              endcase
              // busy drops all but status read
              if (busy_i && op_nx != `SFIF_OP_RDSR1 && op_nx != `SFIF_OP_RDSR2)
                ph_q <= PH_IGN;
            end
          end
          PH_ADR:
          begin
            // multi-lane address, lane 3 or 1 holds msb
            case (inw_q)
              2'd1:    adr_q <= {adr_q[21:0], din[1:0]};
              2'd2:    adr_q <= {adr_q[19:0], din};
              default: adr_q <= {adr_q[22:0], din[0]};
            endcase
            cnt_q <= cnt_q + stp;
            if (op_q == `SFIF_OP_WRAP && cnt_q == `SFIF_WRAP_NIB * 6'd4)
              wrap_setting_bits_o <= din[2:0];
            if (op_q == `SFIF_OP_WRAP && cnt_q == 6'd28)
            begin
              wrap_set_o <= 1'b1;
              ph_q <= PH_IGN;
            end
            else if (op_q != `SFIF_OP_WRAP && cnt_q + stp == `SFIF_ADDR_BITS)
            begin
              cnt_q <= 6'd0;
              cap_q <= 1'b1;
              case (op_q)
                `SFIF_OP_RD:                        ph_q <= PH_OUT;
                `SFIF_OP_DIO, `SFIF_OP_QIO, `SFIF_OP_DID: ph_q <= PH_MODE;
                `SFIF_OP_FRD, `SFIF_OP_DOR, `SFIF_OP_QOR, `SFIF_OP_SECRD: ph_q <= PH_DUM;
                default:                            ph_q <= PH_IN;
              endcase
            end
          end
          PH_MODE:
          begin
            // mode byte taken but continuous mode not supported
            cnt_q <= cnt_q + stp;
            if (cnt_q + stp == 6'd8)
            begin
              cnt_q <= 6'd0;
              ph_q <= (op_q == `SFIF_OP_QIO) ? PH_DUM : PH_OUT;
            end
          end
          PH_DUM:
          begin
            cnt_q <= cnt_q + 6'd1;
            if (cnt_q + 6'd1 == ((op_q == `SFIF_OP_ID) ? `SFIF_ID_DUMMY :
                (op_q == `SFIF_OP_QIO) ? `SFIF_QIO_GAP : `SFIF_DUMMY_BITS))
              ph_q <= PH_OUT;
          end
          default:
          begin
          end
        endcase
        // pick output lane width from op_q on every rising sclk edge
        case (op_q)
          `SFIF_OP_DOR, `SFIF_OP_DIO, `SFIF_OP_DID: outw_q <= 2'd1;
          `SFIF_OP_QOR, `SFIF_OP_QIO:               outw_q <= 2'd2;
          default:                                  outw_q <= 2'd0;
        endcase
      end
      else if (fall && ph_q == PH_OUT)
      begin
        if (oleft_q == 4'd0)
        begin
          // msb first on each lane group
          osh_q <= nxt_byte << ostp;
          oleft_q <= 4'd8 - ostp;
          lane_o <= (outw_q == 2'd2) ? nxt_byte[7:4] :
                    (outw_q == 2'd1) ? {2'b00, nxt_byte[7:6]} : {2'b00, nxt_byte[7], 1'b0};
          if (op_q == `SFIF_OP_DID)
            idsel_q <= !idsel_q;
          if (from_fifo_q)
            pop_q <= f_valid;
        end
        else
        begin
          osh_q <= osh_q << ostp;
          oleft_q <= oleft_q - ostp;
          lane_o <= obits;
        end
        lane_oe_o <= (outw_q == 2'd2) ? 4'hF : (outw_q == 2'd1) ? 4'h3 : 4'h2;
      end
      if (sel_n)
        oleft_q <= 4'd0;
      if (cap_q)
      begin
        cap_q <= 1'b0;
        from_fifo_q <= (op_q != `SFIF_OP_SECER && op_q != `SFIF_OP_SECPG && !is_wr(op_q));
        if (!is_wr(op_q))
        begin
          rd_req_o <= 1'b1;
          rd_addr_o <= adr_q;
        end
        sec_sel_valid_o <= 1'b0;
        if (adr_q[23:16] == 8'h00 && (adr_q[15:8] == `SFIF_SEC_R0 ||
            adr_q[15:8] == `SFIF_SEC_R1 || adr_q[15:8] == `SFIF_SEC_R2 ||
            adr_q[15:8] == `SFIF_SEC_R3))
        begin
          sec_sel_valid_o <= 1'b1;
          sec_sel_o <= adr_q[13:12];
        end
      end
    end
  end
endmodule

// *** sfif_top_assertions.sv ***
// port-level checks on the instruction front end
`timescale 1ns/1ps
module sfif_top_assertions
(
  input wire       clk_i,
  input wire       rst_i,
  input wire       select_n_i,
  input wire       busy_i,
  input wire       op_done_i,
  input wire [3:0] lane_oe_o,
  input wire       write_latch_flag_o,
  input wire       vol_arm_o,
  input wire       rd_req_o,
  input wire       wr_cmd_o,
  input wire       wrap_set_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_lanes_idle: assert property (
    select_n_i [*5] |-> lane_oe_o == 4'h0)
    else $error("lanes driven while deselected");
  a_latch_set: assert property (
    $rose(write_latch_flag_o) |-> select_n_i && $past(select_n_i, 2))
    else $error("latch rose inside a frame");
  a_latch_done: assert property (
    op_done_i |=> !write_latch_flag_o)
    else $error("latch kept after completion");
  a_write_gate: assert property (
    wr_cmd_o |-> $past(write_latch_flag_o) || $past(vol_arm_o))
    else $error("write issued without enable");
  a_write_frame: assert property (
    wr_cmd_o |-> select_n_i && $past(select_n_i))
    else $error("write issued before select rise");
  a_vol_keep: assert property (
    $rose(vol_arm_o) |-> $stable(write_latch_flag_o))
    else $error("volatile enable moved latch");
  a_busy_block: assert property (
    busy_i [*8] |-> !$rose(write_latch_flag_o) && !wr_cmd_o && !rd_req_o)
    else $error("instruction taken while busy");
  a_req_frame: assert property (
    rd_req_o |-> !$past(select_n_i, 2))
    else $error("read request outside a frame");
  cover property (wr_cmd_o);
  cover property (rd_req_o);
  cover property (wrap_set_o);
endmodule

bind sfif_top sfif_top_assertions sfif_top_assertions_i
(
  .clk_i(clk_i),
  .rst_i(rst_i),
  .select_n_i(select_n_i),
  .busy_i(busy_i),
  .op_done_i(op_done_i),
  .lane_oe_o(lane_oe_o),
  .write_latch_flag_o(write_latch_flag_o),
  .vol_arm_o(vol_arm_o),
  .rd_req_o(rd_req_o),
  .wr_cmd_o(wr_cmd_o),
  .wrap_set_o(wrap_set_o)
);

// *** sfif_host.sv ***
// host controller model driving select, serial clock and lanes
`timescale 1ns/1ps
module sfif_host
(
  input  wire       clk_i,
  input  wire [3:0] lane_i,
  output reg        select_n_o,
  output reg        sclk_o,
  output reg  [3:0] lane_o
);
  initial
  begin
    select_n_o = 1'b1;
    sclk_o = 1'b0;
    lane_o = 4'h0;
  end
  // eight system clocks per serial clock
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic start();
    @(negedge clk_i);
    select_n_o = 1'b0;
    half();
  endtask
  task automatic stop();
    half();
    select_n_o = 1'b1;
    lane_o = ~lane_o;
    repeat (12) @(negedge clk_i);
  endtask
  // msb first, top lane carries top bit
  task automatic shift(input logic [31:0] v, input int n, input int w,
                       input bit drv, output logic [31:0] r);
    logic [3:0] c;
    r = 32'h0;
    for (int k = n - 1; k >= 0; k--)
    begin
      c = 4'((v >> (k * w)) & ((1 << w) - 1));
      // released lines toggle so stale values never pass
      lane_o = drv ? c : ~lane_o;
      half();
      sclk_o = 1'b1;
      half();
      r = (r << w) | (w == 1 ? 32'(lane_i[1]) : 32'(lane_i) & ((1 << w) - 1));
      sclk_o = 1'b0;
    end
  endtask
endmodule

// *** sfif_top_bench.sv ***
// self-checking bench for the instruction front end
`timescale 1ns/1ps
module sfif_top_bench;
  // part and maker codes: arbitrary values
  localparam logic [7:0] PART  = 8'h5A;
  localparam logic [7:0] MAKER = 8'hA5;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        busy_i = 1'b0;
  logic        op_done_i = 1'b0;
  logic        rd_valid_i = 1'b0;
  logic [7:0]  rd_data_i = 8'h00;
  logic [7:0]  status1_i = 8'hA6;
  logic [7:0]  status2_i = 8'h3C;
  logic        taken = 1'b0;
  logic        full_seen = 1'b0;
  logic [31:0] rv;
  logic [23:0] a;
  logic [7:0]  feed_q[$];
  logic [7:0]  rop[6] = '{8'h03, 8'h0B, 8'h3B, 8'h6B, 8'hBB, 8'hEB};
  int          raw[6] = '{1, 1, 1, 1, 2, 4};
  int          rdw[6] = '{1, 1, 2, 4, 2, 4};
  int          mismatches = 0;
  int          check_count = 0;
  int          wr_cnt = 0;
  int          rd_cnt = 0;
  int          wrap_cnt = 0;
  int          nb = 1;
  int          n;
  wire         select_n_i;
  wire         sclk_i;
  wire  [3:0]  host_lane;
  wire  [3:0]  lane_o;
  wire  [3:0]  lane_oe_o;
  wire  [3:0]  lane_i = (lane_oe_o & lane_o) | (~lane_oe_o & host_lane);
  wire         write_latch_flag_o;
  wire         vol_arm_o;
  wire         rd_req_o;
  wire  [23:0] rd_addr_o;
  wire         rd_ready_o;
  wire         wr_cmd_o;
  wire  [7:0]  wr_op_o;
  wire  [23:0] wr_addr_o;
  wire  [6:4]  wrap_setting_bits_o;
  wire         wrap_set_o;
  wire         sec_sel_valid_o;
  wire  [1:0]  sec_sel_o;
  sfif_top #(.PART_CODE(PART), .MAKER_CODE(MAKER)) sfif_top_i
  (
    .clk_i(clk_i), .rst_i(rst_i), .select_n_i(select_n_i), .sclk_i(sclk_i),
    .lane_i(lane_i), .lane_o(lane_o), .lane_oe_o(lane_oe_o), .busy_i(busy_i),
    .status1_i(status1_i), .status2_i(status2_i), .op_done_i(op_done_i),
    .write_latch_flag_o(write_latch_flag_o), .vol_arm_o(vol_arm_o),
    .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o), .rd_valid_i(rd_valid_i),
    .rd_ready_o(rd_ready_o), .rd_data_i(rd_data_i), .wr_cmd_o(wr_cmd_o),
    .wr_op_o(wr_op_o), .wr_addr_o(wr_addr_o), .wrap_set_o(wrap_set_o),
    .wrap_setting_bits_o(wrap_setting_bits_o), .sec_sel_o(sec_sel_o),
    .sec_sel_valid_o(sec_sel_valid_o)
  );
  sfif_host sfif_host_i
  (
    .clk_i(clk_i), .lane_i(lane_i), .select_n_o(select_n_i),
    .sclk_o(sclk_i), .lane_o(host_lane)
  );
  always #20 clk_i = ~clk_i;
  function automatic logic [7:0] arr(input logic [23:0] ad);
    return ad[7:0] ^ 8'h96;
  endfunction
  always @(posedge clk_i)
  begin
    taken <= rd_valid_i && rd_ready_o === 1'b1;
    if (rd_valid_i && rd_ready_o === 1'b0)
      full_seen <= 1'b1;
    if (wr_cmd_o === 1'b1)
      wr_cnt <= wr_cnt + 1;
    if (rd_req_o === 1'b1)
      rd_cnt <= rd_cnt + 1;
    if (wrap_set_o === 1'b1)
      wrap_cnt <= wrap_cnt + 1;
  end
  // array side answers each request with nb bytes
  always @(negedge clk_i)
  begin
    if (taken)
      void'(feed_q.pop_front());
    if (rd_req_o === 1'b1)
      for (int k = 0; k < nb; k++)
        feed_q.push_back(arr(rd_addr_o + 24'(k)));
    rd_valid_i = feed_q.size() > 0;
    rd_data_i = feed_q.size() > 0 ? feed_q[0] : 8'h00;
  end
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (mismatches == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic op(input logic [7:0] c);
    sfif_host_i.start();
    sfif_host_i.shift({24'h0, c}, 8, 1, 1'b1, rv);
  endtask
  task automatic simple(input logic [7:0] c);
    op(c);
    sfif_host_i.stop();
  endtask
  task automatic wcmd(input logic [7:0] c, input int b);
    op(c);
    sfif_host_i.shift(32'h012345 >> (24 - b), b, 1, 1'b1, rv);
    sfif_host_i.stop();
  endtask
  initial
  begin
    #2000000;
    mismatches++;
    conclude();
  end
  initial
  begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    check("latch", 0, write_latch_flag_o);
    simple(8'h06);
    n = wr_cnt;
    wcmd(8'h20, 24);
    check("write count", n + 1, wr_cnt);
    check("write op", 8'h20, wr_op_o);
    check("write addr", 24'h012345, wr_addr_o);
    op_done_i = 1'b1;
    @(negedge clk_i);
    op_done_i = 1'b0;
    @(negedge clk_i);
    check("latch", 0, write_latch_flag_o);
    wcmd(8'hD8, 24);
    simple(8'h06);
    wcmd(8'h02, 23);
    check("write count", n + 1, wr_cnt);
    check("latch", 1, write_latch_flag_o);
    busy_i = 1'b1;
    simple(8'h04);
    check("latch busy", 1, write_latch_flag_o);
    for (int s = 0; s < 2; s++)
    begin
      op(s ? 8'h35 : 8'h05);
      sfif_host_i.shift(0, 16, 1, 1'b0, rv);
      sfif_host_i.stop();
      check("status", s ? 16'h3C3C : 16'hA6A6, rv);
    end
    busy_i = 1'b0;
    simple(8'h04);
    check("latch", 0, write_latch_flag_o);
    simple(8'h50);
    check("arm", 1, vol_arm_o);
    check("latch", 0, write_latch_flag_o);
    simple(8'h04);
    check("arm", 0, vol_arm_o);
    op(8'hAB);
    sfif_host_i.shift(0, 24, 1, 1'b1, rv);
    sfif_host_i.shift(0, 16, 1, 1'b0, rv);
    sfif_host_i.stop();
    check("part", {PART, PART}, rv);
    op(8'h92);
    sfif_host_i.shift(0, 16, 2, 1'b1, rv);
    sfif_host_i.shift(0, 8, 2, 1'b0, rv);
    sfif_host_i.stop();
    check("codes", {MAKER, PART}, rv);
    n = wrap_cnt;
    op(8'h77);
    sfif_host_i.shift(32'h00000050, 8, 4, 1'b1, rv);
    sfif_host_i.stop();
    check("wrap count", n + 1, wrap_cnt);
    check("wrap bits", 3'b101, wrap_setting_bits_o);
    // registers 0 to 3 are visited in turn, then an address outside them
    for (int s = 0; s < 5; s++)
    begin
      op(8'h48);
      sfif_host_i.shift(s < 4 ? 32'(s * 4096 + 7) : 32'h011000, 24, 1, 1'b1, rv);
      sfif_host_i.stop();
      check("sec valid", s < 4, sec_sel_valid_o);
      if (s < 4)
        check("sec sel", s, sec_sel_o);
    end
    for (int i = 0; i < 6; i++)
    begin
      a = 24'h0010A0 + 24'(i * 3);
      nb = i == 1 ? 6 : 1;
      n = rd_cnt;
      op(rop[i]);
      if (raw[i] == 1)
        sfif_host_i.shift({8'h0, a}, 24, 1, 1'b1, rv);
      else
        sfif_host_i.shift({a, 8'h00}, 32 / raw[i], raw[i], 1'b1, rv);
      if (i > 0 && i < 4)
        sfif_host_i.shift(0, 8, 1, 1'b1, rv);
      if (i == 5)
        sfif_host_i.shift(0, 4, 4, 1'b0, rv);
      for (int k = 0; k <= nb; k++)
      begin
        sfif_host_i.shift(0, 8 / rdw[i], rdw[i], 1'b0, rv);
        check("read data", k < nb ? arr(a + 24'(k)) : 8'hFF, rv);
      end
      sfif_host_i.stop();
      check("read addr", a, rd_addr_o);
      check("read count", n + 1, rd_cnt);
    end
    check("fifo full", 1, full_seen);
    check("lanes idle", 0, lane_oe_o);
    conclude();
  end
endmodule
